// ===== include/dmamb_regs.svh
`ifndef DMAMB_REGS_SVH
`define DMAMB_REGS_SVH

// Register byte offsets on the APB slave
`define DMAMB_OFS_SRC 8'h00
`define DMAMB_OFS_DST 8'h04
`define DMAMB_OFS_NDP 8'h08
`define DMAMB_OFS_CTL1 8'h0c
`define DMAMB_OFS_CTL2 8'h10
`define DMAMB_OFS_CFG 8'h14
`define DMAMB_OFS_ENA 8'h18
`define DMAMB_OFS_CREQ 8'h1c
`define DMAMB_OFS_SREQ 8'h20
`define DMAMB_OFS_EVT 8'h24

// First control word fields
`define DMAMB_LEN_MSB 15
`define DMAMB_DONE_BIT 31

// Second control word fields
`define DMAMB_C2_SRC_BYP 0
`define DMAMB_C2_DST_BYP 1
`define DMAMB_C2_AUTO 2

// Channel configuration fields
`define DMAMB_CFG_SRC_RLD 0
`define DMAMB_CFG_DST_RLD 1
`define DMAMB_CFG_SRC_HS 2
`define DMAMB_CFG_DST_HS 3
`define DMAMB_CFG_SRC_PER 4
`define DMAMB_CFG_DST_PER 5
`define DMAMB_CFG_MSB 5

// Event mask (low) and sticky status (high) fields
`define DMAMB_EV_BUF 0
`define DMAMB_EV_CHAIN 1
`define DMAMB_EV_STAT_LSB 8

// Descriptor layout and bus constants
`define DMAMB_DSC_LAST 3'd4
`define DMAMB_DSC_CTL1_OFS 32'h0000000c
`define DMAMB_WORD_STEP 32'h00000004
`define DMAMB_HTRANS_IDLE 2'b00
`define DMAMB_HTRANS_NONSEQ 2'b10
`define DMAMB_HSIZE_WORD 3'b010

`endif

// ===== include/dmamb_pkg.sv
package dmamb_pkg;

  typedef enum logic [13:0] {
    PH_IDLE = 14'h0001,
    PH_FETCH_A = 14'h0002,
    PH_FETCH_D = 14'h0004,
    PH_FIX = 14'h0008,
    PH_STALL = 14'h0010,
    PH_MOVE = 14'h0020,
    PH_RD_A = 14'h0040,
    PH_RD_D = 14'h0080,
    PH_WR_W = 14'h0100,
    PH_WR_A = 14'h0200,
    PH_WR_D = 14'h0400,
    PH_WB_A = 14'h0800,
    PH_WB_D = 14'h1000,
    PH_BEND = 14'h2000
  } dmamb_phase_t;

  typedef struct packed {
    dmamb_phase_t st;
    logic [31:0] source_address;
    logic [31:0] destination_address;
    logic [31:0] next_descriptor_pointer;
    logic [31:0] channel_control_first;
    logic [31:0] channel_control_second;
    logic [5:0] channel_config;
    logic [31:0] init_src;
    logic [31:0] init_dst;
    logic [31:0] init_ctl1;
    logic [31:0] src_end;
    logic [31:0] dst_end;
    logic [31:0] dsc_base;
    logic [15:0] beats;
    logic [2:0] widx;
    logic [31:0] data;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic hwrite;
    logic [1:0] chunk_request_bits;
    logic [1:0] single_request_bits;
    logic [7:0] src_left;
    logic [7:0] dst_left;
    logic src_chunk;
    logic dst_chunk;
    logic [1:0] event_mask;
    logic [1:0] event_stat;
    logic busy;
    logic first;
    logic fetched;
    logic [31:0] prdata;
    logic buf_evt;
    logic chain_evt;
  } dmamb_regs_t;

endpackage

// ===== design/dmamb_top.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "dmamb_regs.svh"

// Function
// R1: Chunk request bits start source/destination chunks
// R2: Hardware clears chunk bit when chunk finishes
// R3: Single request bits start singles, cleared after
// R4: Request bits read back live state
// R5: Addresses updated by fetch, replay or continuation
// R6: Control words updated only by fetch or replay
// R7: Fetch descriptor before each linked buffer
// R8: Write first control word back after buffer
// R9: Non-zero pointer at enable starts linked fetch
// R10: Software ends chain with zero pointer, bypasses
// R11: Auto clear and pointer zero: last buffer as written
// R12: Bypassed side without reload continues contiguously
// R13: No bypass: everything from fetched descriptor
// R14: Bypassed side with reload restores initial address
// R15: Auto with one bypass: reuse length, continue
// R16: Auto both bypass: replay all, reload or continue
// R17: Auto contiguous both sides stalls when unmasked
// R18: Keep enable-time values, restore per buffer
// R19: Buffer event after last destination write, masked
// R20: Chain event at transfer end when unmasked
// R21: Evaluate configuration at buffer end, maybe terminate
// R22: Auto with zero pointer repeats until cleared
// R23: Handshake select zero makes request bits active
// R24: Descriptor is five words from pointer address
module dmamb_top #(
  parameter logic [7:0] CHUNK_BEATS = 8'h04
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp,
  output logic buffer_done_event,
  output logic chain_done_event,
  output logic channel_busy
);
  import dmamb_pkg::*;

  dmamb_regs_t q;
  dmamb_regs_t n;

  logic apb_wr;
  logic apb_setup;
  logic src_need;
  logic dst_need;
  logic src_ok;
  logic dst_ok;
  logic addr_hit;

  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  // Only a software-handshaking peripheral side waits for request bits
  assign src_need = q.channel_config[`DMAMB_CFG_SRC_PER] & // R23
                    ~q.channel_config[`DMAMB_CFG_SRC_HS];
  assign dst_need = q.channel_config[`DMAMB_CFG_DST_PER] & // R23
                    ~q.channel_config[`DMAMB_CFG_DST_HS];
  assign src_ok = ~src_need | (q.src_left != 8'h00);
  assign dst_ok = ~dst_need | (q.dst_left != 8'h00);

  always_comb begin
    case (paddr)
      `DMAMB_OFS_SRC, `DMAMB_OFS_DST, `DMAMB_OFS_NDP, `DMAMB_OFS_CTL1,
      `DMAMB_OFS_CTL2, `DMAMB_OFS_CFG, `DMAMB_OFS_ENA, `DMAMB_OFS_CREQ,
      `DMAMB_OFS_SREQ, `DMAMB_OFS_EVT: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = q.prdata;
  assign haddr = q.haddr;
  assign hwrite = q.hwrite;
  assign hwdata = q.hwdata;
  assign hsize = `DMAMB_HSIZE_WORD;
  assign htrans = (q.st == PH_FETCH_A || q.st == PH_RD_A || q.st == PH_WR_A ||
                   q.st == PH_WB_A) ? `DMAMB_HTRANS_NONSEQ : `DMAMB_HTRANS_IDLE;
  assign buffer_done_event = q.buf_evt;
  assign chain_done_event = q.chain_evt;
  assign channel_busy = q.busy;

  always_comb begin
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic last_buf;
    logic sb;
    logic db;
    ev_set = 2'b00;
    ev_clr = 2'b00;
    last_buf = 1'b0;
    sb = q.channel_control_second[`DMAMB_C2_SRC_BYP];
    db = q.channel_control_second[`DMAMB_C2_DST_BYP];
    n = q;
    n.buf_evt = 1'b0;
    n.chain_evt = 1'b0;

    // Transaction credit is loaded only when the side is idle
    if (q.src_left == 8'h00 && src_need) begin
      if (q.chunk_request_bits[0]) begin
        n.src_left = CHUNK_BEATS; // R1
        n.src_chunk = 1'b1;
      end else if (q.single_request_bits[0]) begin
        n.src_left = 8'h01; // R3
        n.src_chunk = 1'b0;
      end
    end
    if (q.dst_left == 8'h00 && dst_need) begin
      if (q.chunk_request_bits[1]) begin
        n.dst_left = CHUNK_BEATS; // R1
        n.dst_chunk = 1'b1;
      end else if (q.single_request_bits[1]) begin
        n.dst_left = 8'h01; // R3
        n.dst_chunk = 1'b0;
      end
    end

    unique case (q.st)
      PH_IDLE: begin
      end
      PH_FETCH_A: begin
        if (hready) begin
          n.st = PH_FETCH_D;
        end
      end
      PH_FETCH_D: begin
        if (hready) begin
          unique case (q.widx) // R24
            3'd0: n.source_address = hrdata; // R7
            3'd1: n.destination_address = hrdata;
            3'd2: n.next_descriptor_pointer = hrdata;
            3'd3: n.channel_control_first = hrdata;
            default: n.channel_control_second = hrdata;
          endcase
          if (q.widx == `DMAMB_DSC_LAST) begin
            n.fetched = 1'b1;
            n.st = PH_FIX;
          end else begin
            n.widx = q.widx + 3'd1;
            n.haddr = q.haddr + `DMAMB_WORD_STEP; // R24
            n.st = PH_FETCH_A;
          end
        end
      end
      PH_FIX: begin
        // Bypassed sides override the descriptor, except on the first buffer and on a final buffer
        if (!q.first && (q.channel_control_second[`DMAMB_C2_AUTO] || // R11
            q.next_descriptor_pointer != 32'h00000000)) begin
          if (sb) begin
            n.source_address = q.channel_config[`DMAMB_CFG_SRC_RLD] ? // R12 R14
                               q.init_src : q.src_end; // R5
          end
          if (db) begin
            n.destination_address = q.channel_config[`DMAMB_CFG_DST_RLD] ? // R12 R14
                                    q.init_dst : q.dst_end; // R5
          end
          if (sb && db && !q.fetched) begin
            n.channel_control_first = q.init_ctl1; // R6 R16 R18
          end
        end
        if (!q.first && q.channel_control_second[`DMAMB_C2_AUTO]) begin
          n.beats = q.init_ctl1[`DMAMB_LEN_MSB:0]; // R15 R16
        end else begin
          n.beats = q.channel_control_first[`DMAMB_LEN_MSB:0]; // R11 R13
        end
        n.first = 1'b0;
        if (!q.first && q.channel_control_second[`DMAMB_C2_AUTO] && sb && db &&
            !q.channel_config[`DMAMB_CFG_SRC_RLD] &&
            !q.channel_config[`DMAMB_CFG_DST_RLD] && q.event_mask[`DMAMB_EV_BUF]) begin
          n.st = PH_STALL; // R17
        end else begin
          n.st = PH_MOVE;
        end
      end
      PH_STALL: begin
        // Held until software acknowledges the buffer event
        if (!q.event_stat[`DMAMB_EV_BUF]) begin
          n.st = PH_MOVE; // R17
        end
      end
      PH_MOVE: begin
        if (q.beats == 16'h0000) begin
          if (q.fetched) begin
            n.haddr = q.dsc_base + `DMAMB_DSC_CTL1_OFS; // R8
            n.hwdata = q.channel_control_first;
            n.hwdata[`DMAMB_DONE_BIT] = 1'b1;
            n.hwrite = 1'b1;
            n.st = PH_WB_A;
          end else begin
            n.st = PH_BEND;
          end
        end else if (src_ok) begin
          n.haddr = q.source_address;
          n.hwrite = 1'b0;
          n.st = PH_RD_A;
        end
      end
      PH_RD_A: begin
        if (hready) begin
          n.st = PH_RD_D;
        end
      end
      PH_RD_D: begin
        if (hready) begin
          n.data = hrdata;
          n.source_address = q.source_address + `DMAMB_WORD_STEP;
          if (q.src_left != 8'h00) begin
            n.src_left = q.src_left - 8'h01;
            if (q.src_left == 8'h01) begin
              if (q.src_chunk) begin
                n.chunk_request_bits[0] = 1'b0; // R2
              end else begin
                n.single_request_bits[0] = 1'b0; // R3
              end
            end
          end
          n.st = PH_WR_W;
        end
      end
      PH_WR_W: begin
        if (dst_ok) begin
          n.haddr = q.destination_address;
          n.hwdata = q.data;
          n.hwrite = 1'b1;
          n.st = PH_WR_A;
        end
      end
      PH_WR_A: begin
        if (hready) begin
          n.st = PH_WR_D;
        end
      end
      PH_WR_D: begin
        if (hready) begin
          n.hwrite = 1'b0;
          n.destination_address = q.destination_address + `DMAMB_WORD_STEP;
          n.beats = q.beats - 16'h0001;
          if (q.dst_left != 8'h00) begin
            n.dst_left = q.dst_left - 8'h01;
            if (q.dst_left == 8'h01) begin
              if (q.dst_chunk) begin
                n.chunk_request_bits[1] = 1'b0; // R2
              end else begin
                n.single_request_bits[1] = 1'b0; // R3
              end
            end
          end
          n.st = PH_MOVE;
        end
      end
      PH_WB_A: begin
        if (hready) begin
          n.st = PH_WB_D;
        end
      end
      PH_WB_D: begin
        if (hready) begin
          n.hwrite = 1'b0;
          n.st = PH_BEND;
        end
      end
      PH_BEND: begin
        // Last destination beat has completed by now
        ev_set[`DMAMB_EV_BUF] = 1'b1;
        n.buf_evt = q.event_mask[`DMAMB_EV_BUF]; // R19
        n.src_end = q.source_address;
        n.dst_end = q.destination_address;
        last_buf = !q.channel_control_second[`DMAMB_C2_AUTO] && // R21 R22
                   (q.next_descriptor_pointer == 32'h00000000);
        if (last_buf) begin
          ev_set[`DMAMB_EV_CHAIN] = 1'b1;
          n.chain_evt = q.event_mask[`DMAMB_EV_CHAIN]; // R20
          n.busy = 1'b0; // R21
          n.st = PH_IDLE;
        end else if (!(sb && db) && q.next_descriptor_pointer != 32'h00000000) begin
          n.dsc_base = q.next_descriptor_pointer; // R7 R13
          n.haddr = q.next_descriptor_pointer;
          n.widx = 3'd0;
          n.fetched = 1'b0;
          n.st = PH_FETCH_A;
        end else begin
          n.fetched = 1'b0; // R16 R22
          n.st = PH_FIX;
        end
      end
      default: begin
        n.st = PH_IDLE;
      end
    endcase

    // APB writes; hardware clears above lose to a same-cycle set here
    if (apb_wr) begin
      unique case (paddr)
        `DMAMB_OFS_SRC: n.source_address = pwdata;
        `DMAMB_OFS_DST: n.destination_address = pwdata;
        `DMAMB_OFS_NDP: n.next_descriptor_pointer = pwdata;
        `DMAMB_OFS_CTL1: n.channel_control_first = pwdata;
        `DMAMB_OFS_CTL2: n.channel_control_second = pwdata; // R22
        `DMAMB_OFS_CFG: n.channel_config = pwdata[`DMAMB_CFG_MSB:0];
        `DMAMB_OFS_ENA: begin
          if (pwdata[0] && !q.busy) begin
            n.busy = 1'b1;
            n.first = 1'b1;
            n.fetched = 1'b0;
            n.init_src = q.source_address; // R18
            n.init_dst = q.destination_address;
            n.init_ctl1 = q.channel_control_first;
            if (q.next_descriptor_pointer != 32'h00000000) begin
              n.dsc_base = q.next_descriptor_pointer; // R9
              n.haddr = q.next_descriptor_pointer;
              n.widx = 3'd0;
              n.st = PH_FETCH_A;
            end else begin
              n.st = PH_FIX; // R11
            end
          end
        end
        `DMAMB_OFS_CREQ: begin
          n.chunk_request_bits = n.chunk_request_bits | // R1
                                 (pwdata[1:0] & {dst_need, src_need});
        end
        `DMAMB_OFS_SREQ: begin
          n.single_request_bits = n.single_request_bits | // R3
                                  (pwdata[1:0] & {dst_need, src_need});
        end
        `DMAMB_OFS_EVT: begin
          n.event_mask = pwdata[1:0];
          ev_clr = pwdata[`DMAMB_EV_STAT_LSB+1:`DMAMB_EV_STAT_LSB];
        end
        default: begin
        end
      endcase
    end
    n.event_stat = (q.event_stat & ~ev_clr) | ev_set;

    // Read data is captured in the setup cycle, live request state included
    if (apb_setup && !pwrite) begin
      unique case (paddr)
        `DMAMB_OFS_SRC: n.prdata = q.source_address;
        `DMAMB_OFS_DST: n.prdata = q.destination_address;
        `DMAMB_OFS_NDP: n.prdata = q.next_descriptor_pointer;
        `DMAMB_OFS_CTL1: n.prdata = q.channel_control_first;
        `DMAMB_OFS_CTL2: n.prdata = q.channel_control_second;
        `DMAMB_OFS_CFG: n.prdata = {26'h0000000, q.channel_config};
        `DMAMB_OFS_ENA: n.prdata = {31'h00000000, q.busy};
        `DMAMB_OFS_CREQ: n.prdata = {30'h00000000, q.chunk_request_bits}; // R4
        `DMAMB_OFS_SREQ: n.prdata = {30'h00000000, q.single_request_bits}; // R4
        `DMAMB_OFS_EVT: n.prdata = {22'h000000, q.event_stat, 6'h00, q.event_mask};
        default: n.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= PH_IDLE;
    end else begin
      q <= n;
    end
  end

endmodule

// ===== verification/dmamb_top_sva.sv
`timescale 1ns/100ps
module dmamb_top_sva #(
  parameter logic [7:0] CHUNK_BEATS = 8'h04
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic buffer_done_event,
  input wire logic chain_done_event,
  input wire logic channel_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_slverr;
    psel && penable |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'b00);
  endproperty
  a_slverr: assert property (p_slverr) else $error("bad slave error");
  property p_hsize;
    htrans == 2'b10 |-> hsize == 3'b010;
  endproperty
  a_hsize: assert property (p_hsize) else $error("not word size");
  property p_hold;
    htrans == 2'b10 && !hready |=> htrans == 2'b10 && $stable(haddr) && $stable(hwrite);
  endproperty
  a_hold: assert property (p_hold) else $error("address phase dropped");
  property p_nopipe;
    htrans == 2'b10 && hready |=> htrans == 2'b00;
  endproperty
  a_nopipe: assert property (p_nopipe) else $error("pipelined request");
  property p_wdata;
    htrans == 2'b10 && hwrite && hready |=> $stable(hwdata) && hwrite;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  property p_buf_pulse;
    buffer_done_event |=> !buffer_done_event;
  endproperty
  a_buf_pulse: assert property (p_buf_pulse) else $error("buffer pulse too long");
  property p_buf_gap;
    buffer_done_event |-> $past(htrans) == 2'b00 && $past(channel_busy);
  endproperty
  a_buf_gap: assert property (p_buf_gap) else $error("buffer pulse mid transfer");
  property p_chain_end;
    chain_done_event |-> $past(channel_busy) && !channel_busy ##1 !chain_done_event;
  endproperty
  a_chain_end: assert property (p_chain_end) else $error("chain pulse not at end");
  property p_idle;
    !channel_busy |-> htrans == 2'b00;
  endproperty
  a_idle: assert property (p_idle) else $error("bus used while idle");
endmodule
bind dmamb_top dmamb_top_sva #(.CHUNK_BEATS(CHUNK_BEATS)) u_dmamb_top_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .buffer_done_event(buffer_done_event),
  .chain_done_event(chain_done_event), .channel_busy(channel_busy));

// ===== verification/dmamb_mem.sv
`timescale 1ns/100ps
module dmamb_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready
);
  logic [31:0] mem [0:63];
  logic dph, dwr, tick;
  logic [5:0] dadr;
  // Slow mode waits every other cycle
  assign hready = !slow || tick;
  // Garbage outside a read data phase
  assign hrdata = (dph && !dwr) ? mem[dadr] : ~mem[dadr];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph <= 1'b0;
      dwr <= 1'b0;
      dadr <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (hready) begin
        if (dph && dwr) mem[dadr] <= hwdata;
        dph <= htrans == 2'b10;
        dwr <= hwrite;
        dadr <= haddr[7:2];
      end
    end
  end
endmodule

// ===== verification/tb.sv
`timescale 1ns/100ps
`include "dmamb_regs.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, haddr, hwdata, hrdata, rd;
  logic pready, pslverr, hwrite, hready, err, buffer_done_event, chain_done_event, channel_busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int fails = 0;
  int cmp_count = 0;
  int nbuf = 0;
  int nchain = 0;
  always #20 pclk = ~pclk;
  dmamb_top #(.CHUNK_BEATS(8'h02)) u_dmamb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(1'b0),
    .buffer_done_event(buffer_done_event), .chain_done_event(chain_done_event),
    .channel_busy(channel_busy));
  dmamb_mem u_dmamb_mem (.hclk(pclk), .hresetn(presetn), .slow(slow), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hready(hready));
  always @(negedge pclk) begin
    if (buffer_done_event === 1'b1) nbuf++;
    if (chain_done_event === 1'b1) nchain++;
  end
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ev(input logic want_buf);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((want_buf ? buffer_done_event !== 1'b1 : channel_busy !== 1'b0) && n < 3000);
    if (n >= 3000) begin
      fails++;
      give_verdict();
    end
    // Let the event counters settle before they are read
    @(posedge pclk);
  endtask
  task automatic poll(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 200);
    if (n >= 200) begin
      fails++;
      give_verdict();
    end
    // The last beat's write may still be in flight
    repeat (4) @(posedge pclk);
  endtask
  task automatic fill();
    for (int i = 0; i < 64; i++) u_dmamb_mem.mem[i] = 32'h5a000000 | 32'(i * 4);
  endtask
  // Word at d must hold the fill pattern of address s
  task automatic cpy(input logic [7:0] d, input logic [7:0] s, input int n);
    for (int i = 0; i < n; i++) chk(u_dmamb_mem.mem[d[7:2] + i], 32'h5a000000 | (s + i * 4));
  endtask
  task automatic dsc(input logic [7:0] b, input logic [31:0] s, d, p, c1, c2);
    u_dmamb_mem.mem[b[7:2]] = s;
    u_dmamb_mem.mem[b[7:2] + 1] = d;
    u_dmamb_mem.mem[b[7:2] + 2] = p;
    u_dmamb_mem.mem[b[7:2] + 3] = c1;
    u_dmamb_mem.mem[b[7:2] + 4] = c2;
  endtask
  task automatic prog(input logic [31:0] s, d, p, c1, c2, cf);
    apb(1'b1, `DMAMB_OFS_SRC, s);
    apb(1'b1, `DMAMB_OFS_DST, d);
    apb(1'b1, `DMAMB_OFS_NDP, p);
    apb(1'b1, `DMAMB_OFS_CTL1, c1);
    apb(1'b1, `DMAMB_OFS_CTL2, c2);
    apb(1'b1, `DMAMB_OFS_CFG, cf);
    apb(1'b1, `DMAMB_OFS_EVT, 32'h303);
    nbuf = 0;
    nchain = 0;
    apb(1'b1, `DMAMB_OFS_ENA, 32'h1);
  endtask
  task automatic t_regs();
    apb(1'b0, `DMAMB_OFS_ENA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `DMAMB_OFS_DST, 32'h84);
    apb(1'b0, `DMAMB_OFS_DST, 32'h0);
    chk(rd, 32'h84);
    apb(1'b0, 8'h28, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_single();
    fill();
    prog(32'h40, 32'h80, 32'h0, 32'h3, 32'h0, 32'h0);
    wait_ev(1'b0);
    cpy(8'h80, 8'h40, 3);
    cpy(8'h8c, 8'h8c, 1);
    chk({nbuf[15:0], nchain[15:0]}, 32'h00010001);
    apb(1'b0, `DMAMB_OFS_EVT, 32'h0);
    chk({22'h0, rd[9:0]}, 32'h303);
  endtask
  task automatic t_chain();
    slow <= 1'b1;
    fill();
    dsc(8'hc0, 32'h40, 32'h90, 32'hd4, 32'h2, 32'h0);
    dsc(8'hd4, 32'h60, 32'ha0, 32'h0, 32'h1, 32'h3);
    prog(32'h10, 32'h20, 32'hc0, 32'h7, 32'h0, 32'h0);
    wait_ev(1'b0);
    cpy(8'h90, 8'h40, 2);
    cpy(8'h98, 8'h98, 1);
    cpy(8'ha0, 8'h60, 1);
    cpy(8'ha4, 8'ha4, 1);
    cpy(8'h20, 8'h20, 1);
    chk({u_dmamb_mem.mem[51][31], u_dmamb_mem.mem[56][31]}, 32'h3);
    chk({nbuf[15:0], nchain[15:0]}, 32'h00020001);
    slow <= 1'b0;
  endtask
  task automatic t_replay();
    fill();
    prog(32'h40, 32'h80, 32'h0, 32'h2, 32'h7, 32'h3);
    wait_ev(1'b1);
    apb(1'b1, `DMAMB_OFS_CTL2, 32'h3);
    wait_ev(1'b0);
    cpy(8'h80, 8'h40, 2);
    cpy(8'h88, 8'h88, 1);
    chk({nbuf[15:0], nchain[15:0]}, 32'h00020001);
  endtask
  task automatic t_stall();
    fill();
    prog(32'h40, 32'h80, 32'h0, 32'h2, 32'h7, 32'h0);
    wait_ev(1'b1);
    for (int i = 0; i < 10; i++) begin
      @(negedge pclk);
      chk({29'h0, channel_busy, htrans}, 32'h4);
    end
    apb(1'b1, `DMAMB_OFS_CTL2, 32'h3);
    apb(1'b1, `DMAMB_OFS_EVT, 32'h103);
    wait_ev(1'b0);
    cpy(8'h80, 8'h40, 4);
    chk(nbuf, 32'h2);
  endtask
  task automatic t_hs();
    fill();
    prog(32'h40, 32'h80, 32'h0, 32'h5, 32'h0, 32'h10);
    apb(1'b1, `DMAMB_OFS_CREQ, 32'h2);
    apb(1'b0, `DMAMB_OFS_CREQ, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    cpy(8'h80, 8'h80, 1);
    apb(1'b1, `DMAMB_OFS_CREQ, 32'h1);
    apb(1'b0, `DMAMB_OFS_CREQ, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    poll(`DMAMB_OFS_CREQ);
    cpy(8'h80, 8'h40, 2);
    cpy(8'h88, 8'h88, 1);
    apb(1'b1, `DMAMB_OFS_SREQ, 32'h1);
    poll(`DMAMB_OFS_SREQ);
    cpy(8'h88, 8'h48, 1);
    cpy(8'h8c, 8'h8c, 1);
    apb(1'b1, `DMAMB_OFS_CREQ, 32'h1);
    wait_ev(1'b0);
    cpy(8'h8c, 8'h4c, 2);
  endtask
  initial begin
    fill();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_single();
    t_chain();
    t_replay();
    t_stall();
    t_hs();
    give_verdict();
  end
endmodule
